/* pmw_partner.sv */
`timescale 1ns/10ps
module pmw_partner #(
  parameter int READY_DLY = 6,
  parameter int WDT_LIMIT = 20
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // device side
  input wire logic primary_osc_en,
  input wire logic wdt_clear,
  output logic primary_ready,
  output logic wdt_timeout,
  // bench control
  input wire logic wdt_run
);
  //------------------------------------------------------------
  // primary oscillator and watchdog
  //------------------------------------------------------------
  int osc_cnt;
  int wdt_cnt;
  // ready only after a start-up count, lost when switched off
  always_ff @(posedge mclk) begin
    if (reset || !primary_osc_en) begin
      osc_cnt <= 0;
      primary_ready <= 1'b0;
    end else begin
      if (osc_cnt < READY_DLY) osc_cnt <= osc_cnt + 1;
      primary_ready <= (osc_cnt >= READY_DLY);
    end
  end
  // periodic timeout, restarted by every clear
  always_ff @(posedge mclk) begin
    if (reset || wdt_clear || !wdt_run) begin
      wdt_cnt <= 0;
      wdt_timeout <= 1'b0;
    end else begin
      wdt_cnt <= (wdt_cnt == WDT_LIMIT - 1) ? 0 : wdt_cnt + 1;
      wdt_timeout <= (wdt_cnt == WDT_LIMIT - 1);
    end
  end
endmodule // pmw_partner

/* pmw_pkg.sv */
//------------------------------------------------------------
// power mode and wake control constants
//------------------------------------------------------------
package pmw_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int CPU_START_DELAY_NS = 2000;
  localparam int OSC_SETTLE_NS = 1000;
  localparam int CPU_START_CYC = (CPU_START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OSC_SETTLE_CYC = (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;

  // register addresses
  localparam logic [11:0] ADDR_WATCHDOG_CONTROL = 12'hfd1;
  localparam logic [11:0] ADDR_OSCILLATOR_CONTROL = 12'hfd3;
  localparam logic [11:0] ADDR_INTERRUPT_CONTROL = 12'hff2;
  localparam logic [11:0] ADDR_POWER_CONFIG = 12'hf58;
  localparam logic [11:0] ADDR_EVENT_STATUS = 12'hf59;
  localparam logic [11:0] ADDR_EVENT_MASK = 12'hf5a;

  // oscillator control fields
  localparam int OSC_IDLE_BIT = 7;
  localparam int OSC_IFS_LSB = 4;
  localparam int OSC_PRIMARY_OSC_TIMEOUT_FLAG_BIT = 3;
  localparam int OSC_INTERNAL_OSC_STABLE_FLAG_BIT = 2;
  localparam int OSC_SCS_HI_BIT = 1;
  localparam int OSC_SCS_LO_BIT = 0;
  // other fields
  localparam int WDT_EN_BIT = 0;
  localparam int CFG_LFSS_BIT = 0;
  localparam int INT_GIE_BIT = 7;
  localparam int INT_SRC_N = 6;
  // event status bits
  localparam int EV_INT_WAKE = 0;
  localparam int EV_WDT_WAKE = 1;
  localparam int EV_WDT_RESET = 2;
  localparam int EV_CLK_FAIL = 3;
  localparam int EV_OSC_STABLE = 4;

  localparam logic [7:0] RESET_BYTE = 8'h00;

  typedef enum logic [4:0] {
    ST_HOLD = 5'h01,
    ST_RUN = 5'h02,
    ST_SLEEP = 5'h04,
    ST_IDLE = 5'h08,
    ST_WAKE = 5'h10
  } pmw_state_t;
endpackage

/* pmw_power_mode_wake_control.sv */
`timescale 1ns/10ps
module pmw_power_mode_wake_control #(
  parameter int CPU_START_CYCLES = pmw_pkg::CPU_START_CYC,
  parameter int OSC_SETTLE_CYCLES = pmw_pkg::OSC_SETTLE_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq,
  // cpu core
  input wire logic sleep_instr,
  input wire logic watchdog_clear_instr,
  output logic cpu_clk_en,
  output logic cpu_resume,
  output logic vector_branch,
  // peripherals and interrupt sources
  input wire logic [pmw_pkg::INT_SRC_N-1:0] int_flags,
  output logic periph_clk_en,
  // watchdog
  input wire logic wdt_timeout,
  output logic wdt_clear,
  output logic wdt_reset_req,
  // oscillators (asynchronous pins)
  input wire logic primary_ready,
  input wire logic clock_lost,
  input wire logic two_speed_enable,
  input wire logic fail_safe_enable,
  output logic primary_osc_en,
  output logic internal_osc_source,
  output logic internal_rc_low_source,
  output logic clk_sel_internal
);
  import pmw_pkg::*;

  localparam logic [CNT_W-1:0] START_LAST = CNT_W'(CPU_START_CYCLES - 1);
  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(OSC_SETTLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

  typedef struct packed {
    pmw_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] setcnt;
    logic idle_sel;
    logic [2:0] ifs;
    logic [1:0] system_clock_select;
    logic primary_osc_timeout_flag;
    logic internal_osc_stable_flag;
    logic lfss;
    logic wdt_en;
    logic [7:0] interrupt_control;
    logic [7:0] stat;
    logic [7:0] mask;
    logic fallback;
    logic prim_off;
    logic wake_int;
    logic [7:0] rdata;
    logic resume;
    logic vector;
    logic wdt_clr;
    logic wdt_rst;
    logic [1:0] prdy_sync;
    logic [2:0] lost_sync;
    logic [1:0] ts_sync;
    logic [1:0] fs_sync;
  } pmw_regs_t;

  pmw_regs_t state_reg;
  pmw_regs_t state_next;

  function automatic logic [7:0] osc_read(input pmw_regs_t s);
    osc_read = RESET_BYTE;
    osc_read[OSC_IDLE_BIT] = s.idle_sel;
    osc_read[OSC_IFS_LSB +: 3] = s.ifs;
    osc_read[OSC_PRIMARY_OSC_TIMEOUT_FLAG_BIT] = s.primary_osc_timeout_flag;
    osc_read[OSC_INTERNAL_OSC_STABLE_FLAG_BIT] = s.internal_osc_stable_flag;
    osc_read[OSC_SCS_HI_BIT] = s.system_clock_select[1];
    osc_read[OSC_SCS_LO_BIT] = s.system_clock_select[0];
  endfunction

  logic prdy;
  logic fscm;
  logic two_speed;
  logic lost_rise;
  logic clk_int;
  logic internal_osc_source_on;
  logic prim_on;
  logic wake_irq;
  logic [7:0] ev;

  //------------------------------------------------------------
  // derived levels
  //------------------------------------------------------------
  assign prdy = state_reg.prdy_sync[1];
  assign fscm = state_reg.fs_sync[1];
  assign two_speed = state_reg.ts_sync[1];
  assign lost_rise = state_reg.lost_sync[1] & ~state_reg.lost_sync[2];
  assign clk_int = state_reg.system_clock_select[1] | state_reg.fallback;
  assign internal_osc_source_on = (state_reg.ifs != 3'h0) | state_reg.lfss;
  assign prim_on = ~state_reg.system_clock_select[1] & ~state_reg.prim_off & (state_reg.st != ST_SLEEP);
  assign wake_irq = |(int_flags & state_reg.interrupt_control[INT_SRC_N-1:0]);

  //------------------------------------------------------------
  // next state
  //------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    ev = RESET_BYTE;
    state_next.resume = 1'b0;
    state_next.vector = 1'b0;
    state_next.wdt_clr = 1'b0;
    state_next.wdt_rst = 1'b0;
    state_next.rdata = RESET_BYTE;
    state_next.prdy_sync = {state_reg.prdy_sync[0], primary_ready};
    state_next.lost_sync = {state_reg.lost_sync[1:0], clock_lost};
    state_next.ts_sync = {state_reg.ts_sync[0], two_speed_enable};
    state_next.fs_sync = {state_reg.fs_sync[0], fail_safe_enable};

    // internal oscillator settle
    if (!internal_osc_source_on) begin
      state_next.setcnt = '0;
      state_next.internal_osc_stable_flag = 1'b0;
    end else if (!state_reg.internal_osc_stable_flag) begin
      if (state_reg.setcnt >= SETTLE_LAST) begin
        state_next.internal_osc_stable_flag = 1'b1;
        ev[EV_OSC_STABLE] = 1'b1;
      end else begin
        state_next.setcnt = state_reg.setcnt + CNT_ONE;
      end
    end

    // primary oscillator status
    if (prim_on && prdy) begin
      state_next.primary_osc_timeout_flag = 1'b1;
      state_next.fallback = 1'b0;
    end else if (clk_int || !prim_on) begin
      state_next.primary_osc_timeout_flag = 1'b0;
    end

    // clock loss with fail-safe monitor
    if (fscm && lost_rise) begin
      state_next.fallback = 1'b1;
      state_next.prim_off = 1'b1;
      state_next.primary_osc_timeout_flag = 1'b0;
      state_next.wdt_clr = 1'b1;
      ev[EV_CLK_FAIL] = 1'b1;
    end
    if (watchdog_clear_instr) begin
      state_next.wdt_clr = 1'b1;
    end

    // mode sequencer
    case (state_reg.st)
      ST_HOLD: begin
        if (prdy) begin
          state_next.st = ST_RUN;
          state_next.resume = 1'b1;
        end else if (two_speed || fscm) begin
          state_next.st = ST_RUN;
          state_next.fallback = 1'b1;
          state_next.resume = 1'b1;
        end
      end
      ST_RUN: begin
        if (wdt_timeout) begin
          state_next.wdt_rst = 1'b1;
          ev[EV_WDT_RESET] = 1'b1;
        end else if (sleep_instr) begin
          state_next.wdt_clr = 1'b1;
          state_next.st = state_reg.idle_sel ? ST_IDLE : ST_SLEEP;
          if (state_reg.fallback) begin
            state_next.prim_off = 1'b1;
          end
        end
      end
      ST_SLEEP, ST_IDLE: begin
        if (wake_irq || wdt_timeout) begin
          state_next.st = ST_WAKE;
          state_next.cnt = '0;
          state_next.wake_int = wake_irq;
          ev[EV_INT_WAKE] = wake_irq;
          ev[EV_WDT_WAKE] = ~wake_irq;
        end
      end
      ST_WAKE: begin
        if (state_reg.cnt >= START_LAST) begin
          state_next.st = ST_RUN;
          state_next.resume = 1'b1;
          state_next.vector = state_reg.wake_int & state_reg.interrupt_control[INT_GIE_BIT];
        end else begin
          state_next.cnt = state_reg.cnt + CNT_ONE;
        end
      end
      default: begin
        state_next.st = ST_HOLD;
      end
    endcase

    // register writes; wake never touches idle or clock select
    if (reg_wr) begin
      case (reg_addr)
        ADDR_OSCILLATOR_CONTROL: begin
          state_next.idle_sel = reg_wdata[OSC_IDLE_BIT];
          state_next.ifs = reg_wdata[OSC_IFS_LSB +: 3];
          state_next.system_clock_select = {reg_wdata[OSC_SCS_HI_BIT], reg_wdata[OSC_SCS_LO_BIT]};
          state_next.prim_off = 1'b0;
          if (clk_int && (reg_wdata[OSC_IFS_LSB +: 3] != state_reg.ifs)) begin
            state_next.wdt_clr = 1'b1;
          end
        end
        ADDR_WATCHDOG_CONTROL: state_next.wdt_en = reg_wdata[WDT_EN_BIT];
        ADDR_INTERRUPT_CONTROL: state_next.interrupt_control = reg_wdata;
        ADDR_POWER_CONFIG: state_next.lfss = reg_wdata[CFG_LFSS_BIT];
        ADDR_EVENT_MASK: state_next.mask = reg_wdata;
        default: begin
        end
      endcase
    end

    // register reads; status cleared by read, new events win
    if (reg_rd) begin
      case (reg_addr)
        ADDR_OSCILLATOR_CONTROL: state_next.rdata = osc_read(state_reg);
        ADDR_WATCHDOG_CONTROL: state_next.rdata = {7'h00, state_reg.wdt_en};
        ADDR_INTERRUPT_CONTROL: state_next.rdata = state_reg.interrupt_control;
        ADDR_POWER_CONFIG: state_next.rdata = {7'h00, state_reg.lfss};
        ADDR_EVENT_MASK: state_next.rdata = state_reg.mask;
        ADDR_EVENT_STATUS: begin
          state_next.rdata = state_reg.stat;
          state_next.stat = RESET_BYTE;
        end
        default: state_next.rdata = RESET_BYTE;
      endcase
    end
    state_next.stat = state_next.stat | ev;
  end

  //------------------------------------------------------------
  // state register
  //------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg <= '{st: ST_HOLD, default: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  //------------------------------------------------------------
  // outputs
  //------------------------------------------------------------
  assign reg_rdata = state_reg.rdata;
  assign irq = |(state_reg.stat & state_reg.mask);
  assign cpu_clk_en = (state_reg.st == ST_RUN);
  assign periph_clk_en = (state_reg.st == ST_RUN) || (state_reg.st == ST_IDLE) || (state_reg.st == ST_WAKE);
  assign cpu_resume = state_reg.resume;
  assign vector_branch = state_reg.vector;
  assign wdt_clear = state_reg.wdt_clr;
  assign wdt_reset_req = state_reg.wdt_rst;
  assign primary_osc_en = prim_on;
  assign internal_osc_source = internal_osc_source_on;
  assign internal_rc_low_source = state_reg.wdt_en | fscm;
  assign clk_sel_internal = clk_int;

  //------------------------------------------------------------
  // assertions
  //------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_idle_cpu_stop: assert property ((state_reg.st == ST_IDLE) |-> (!cpu_clk_en && periph_clk_en))
    else $error("idle mode clocks wrong");
  a_sleep_to_idle: assert property ((cpu_clk_en && sleep_instr && !wdt_timeout && state_reg.idle_sel)
    |=> (state_reg.st == ST_IDLE) ##1 !cpu_clk_en)
    else $error("sleep with idle select did not enter idle");
  a_internal_stops_primary: assert property ($rose(state_reg.system_clock_select[1]) |-> !primary_osc_en ##1 !state_reg.primary_osc_timeout_flag)
    else $error("primary oscillator not stopped on internal switch");
  a_internal_osc_source_enable: assert property ((state_reg.ifs != 3'h0) |-> internal_osc_source)
    else $error("internal oscillator not enabled");
  a_stable_after_settle: assert property ($rose(state_reg.internal_osc_stable_flag) |-> $past(state_reg.setcnt) >= SETTLE_LAST)
    else $error("stable flag set before settle time");
  a_stable_held: assert property ((state_reg.internal_osc_stable_flag && internal_osc_source) |=> state_reg.internal_osc_stable_flag)
    else $error("stable flag dropped while oscillator enabled");
  a_internal_osc_source_off: assert property (!internal_osc_source |=> !state_reg.internal_osc_stable_flag)
    else $error("stable flag set with oscillator off");
  a_start_delay: assert property ((state_reg.st == ST_WAKE && state_reg.cnt >= START_LAST)
    |=> cpu_clk_en && cpu_resume)
    else $error("cpu did not resume after start delay");
  a_wake_no_cpu: assert property ((state_reg.st == ST_WAKE) |-> !cpu_clk_en && periph_clk_en)
    else $error("cpu clocked during start delay");
  a_low_rc_on: assert property ((state_reg.wdt_en || fscm) |-> internal_rc_low_source)
    else $error("low rc source stopped");
  a_wake_cause: assert property (((state_reg.st == ST_SLEEP) && !wake_irq && !wdt_timeout) |=> (state_reg.st == ST_SLEEP))
    else $error("sleep left without cause");
  a_vector_gie: assert property (vector_branch |-> cpu_resume && state_reg.interrupt_control[INT_GIE_BIT])
    else $error("vector branch without global enable");
  a_wdt_run_reset: assert property ((cpu_clk_en && wdt_timeout) |=> wdt_reset_req)
    else $error("watchdog timeout in run gave no reset");
  a_wdt_clr_sleep: assert property ((cpu_clk_en && sleep_instr && !wdt_timeout) |=> wdt_clear)
    else $error("sleep did not clear watchdog");
  a_unused_zero: assert property ((reg_rd && reg_addr == 12'hfd4) |=> (reg_rdata == 8'h00))
    else $error("unused address read nonzero");

  c_idle_entry: cover property ((state_reg.st == ST_RUN) ##1 (state_reg.st == ST_IDLE));
  c_int_wake_vector: cover property (vector_branch);
  c_wdt_reset: cover property (wdt_reset_req);
  c_two_speed: cover property (cpu_clk_en && state_reg.fallback);
endmodule // pmw_power_mode_wake_control

/* pmw_power_mode_wake_control_test.sv */
`timescale 1ns/10ps
module pmw_power_mode_wake_control_test;
  import pmw_pkg::*;
  localparam int CPU_START = 4;
  localparam int SETTLE = 3;
  localparam int WDT_LIM = 20;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0, reg_rd = 1'b0, sleep_instr = 1'b0, watchdog_clear_instr = 1'b0, wdt_run = 1'b0;
  logic clock_lost = 1'b0, two_speed_enable = 1'b0, fail_safe_enable = 1'b0;
  logic [5:0] int_flags = 6'h00;
  logic [7:0] reg_rdata;
  logic irq, cpu_clk_en, cpu_resume, vector_branch, periph_clk_en, wdt_timeout, wdt_clear;
  logic wdt_reset_req, primary_ready, primary_osc_en, internal_osc_source, internal_rc_low_source;
  logic clk_sel_internal;
  int n_fail = 0;
  int n_tests = 0;
  int n;

  always #10 mclk = ~mclk;

  pmw_power_mode_wake_control #(.CPU_START_CYCLES(CPU_START), .OSC_SETTLE_CYCLES(SETTLE))
    pmw_power_mode_wake_control_i (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .sleep_instr(sleep_instr),
    .watchdog_clear_instr(watchdog_clear_instr), .cpu_clk_en(cpu_clk_en), .cpu_resume(cpu_resume),
    .vector_branch(vector_branch), .int_flags(int_flags), .periph_clk_en(periph_clk_en),
    .wdt_timeout(wdt_timeout), .wdt_clear(wdt_clear), .wdt_reset_req(wdt_reset_req),
    .primary_ready(primary_ready), .clock_lost(clock_lost), .two_speed_enable(two_speed_enable),
    .fail_safe_enable(fail_safe_enable), .primary_osc_en(primary_osc_en),
    .internal_osc_source(internal_osc_source), .internal_rc_low_source(internal_rc_low_source),
    .clk_sel_internal(clk_sel_internal));

  pmw_partner #(.READY_DLY(6), .WDT_LIMIT(WDT_LIM)) pmw_partner_i (.mclk(mclk), .reset(reset),
    .primary_osc_en(primary_osc_en), .wdt_clear(wdt_clear), .primary_ready(primary_ready),
    .wdt_timeout(wdt_timeout), .wdt_run(wdt_run));

  //------------------------------------------------------------
  // tasks
  //------------------------------------------------------------
  task automatic end_of_test();
    if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic pulse_sleep();
    @(posedge mclk);
    sleep_instr <= 1'b1;
    @(posedge mclk);
    sleep_instr <= 1'b0;
    #1;
  endtask

  task automatic wait_for(input int which, output int cnt);
    cnt = 0;
    do begin
      @(posedge mclk);
      #1;
      cnt++;
      if (cnt > 200) begin
        n_fail++;
        $display("[ERR] %0t wait ran out", $time);
        end_of_test();
      end
    end while (!((which == 0) ? (cpu_resume === 1'b1) : (wdt_reset_req === 1'b1)));
  endtask

  //------------------------------------------------------------
  // main sequence
  //------------------------------------------------------------
  initial begin
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    wait_for(0, n);
    rdchk(ADDR_OSCILLATOR_CONTROL, 8'h08);
    rdchk(ADDR_INTERRUPT_CONTROL, 8'h00);
    wr(12'hfd4, 8'hff);
    rdchk(12'hfd4, 8'h00);
    wr(ADDR_WATCHDOG_CONTROL, 8'h01);
    rdchk(ADDR_WATCHDOG_CONTROL, 8'h01);
    chk(internal_rc_low_source, 1'b1);
    wr(ADDR_WATCHDOG_CONTROL, 8'h00);
    wr(ADDR_POWER_CONFIG, 8'h01);
    repeat (SETTLE + 3) @(posedge mclk);
    rdchk(ADDR_OSCILLATOR_CONTROL, 8'h0c);
    chk(internal_osc_source, 1'b1);
    wr(ADDR_POWER_CONFIG, 8'h00);
    rdchk(ADDR_OSCILLATOR_CONTROL, 8'h08);
    chk(internal_osc_source, 1'b0);
    // idle entry from another run mode: idle select first, then clock select
    wr(ADDR_OSCILLATOR_CONTROL, 8'h80);
    wr(ADDR_OSCILLATOR_CONTROL, 8'hf2);
    repeat (SETTLE + 3) @(posedge mclk);
    rdchk(ADDR_OSCILLATOR_CONTROL, 8'hf6);
    chk(primary_osc_en, 1'b0);
    chk(clk_sel_internal, 1'b1);
    wr(ADDR_INTERRUPT_CONTROL, 8'h81);
    pulse_sleep();
    chk(cpu_clk_en, 1'b0);
    chk(periph_clk_en, 1'b1);
    chk(wdt_clear, 1'b1);
    rdchk(ADDR_OSCILLATOR_CONTROL, 8'hf6);
    @(posedge mclk);
    int_flags <= 6'h01;
    wait_for(0, n);
    chk(n, CPU_START + 1);
    chk(vector_branch, 1'b1);
    @(posedge mclk);
    int_flags <= 6'h00;
    rdchk(ADDR_OSCILLATOR_CONTROL, 8'hf6);
    @(posedge mclk);
    watchdog_clear_instr <= 1'b1;
    @(posedge mclk);
    watchdog_clear_instr <= 1'b0;
    #1;
    chk(wdt_clear, 1'b1);
    // full sleep, only the enabled flag may wake
    wr(ADDR_OSCILLATOR_CONTROL, 8'h00);
    #1;
    chk(wdt_clear, 1'b1);
    wr(ADDR_INTERRUPT_CONTROL, 8'h02);
    repeat (12) @(posedge mclk);
    pulse_sleep();
    chk(periph_clk_en, 1'b0);
    @(posedge mclk);
    int_flags <= 6'h01;
    repeat (10) @(posedge mclk);
    #1;
    chk(cpu_clk_en, 1'b0);
    @(posedge mclk);
    int_flags <= 6'h02;
    wait_for(0, n);
    chk(n, CPU_START + 1);
    chk(vector_branch, 1'b0);
    @(posedge mclk);
    int_flags <= 6'h00;
    // watchdog timeout: wake in sleep, reset request in run
    @(posedge mclk);
    wdt_run <= 1'b1;
    pulse_sleep();
    wait_for(0, n);
    chk(n >= WDT_LIM && n <= WDT_LIM + CPU_START + 3, 1'b1);
    wait_for(1, n);
    @(posedge mclk);
    wdt_run <= 1'b0;
    // sticky events, mask and read-to-clear
    wr(ADDR_EVENT_MASK, 8'h02);
    rdchk(ADDR_EVENT_MASK, 8'h02);
    chk(irq, 1'b1);
    rdchk(ADDR_EVENT_STATUS, 8'h17);
    rdchk(ADDR_EVENT_STATUS, 8'h00);
    chk(irq, 1'b0);
    // fail-safe start-up after a second reset, then clock loss
    @(posedge mclk);
    reset <= 1'b1;
    fail_safe_enable <= 1'b1;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    wait_for(0, n);
    chk(n, 3);
    chk(clk_sel_internal, 1'b1);
    chk(internal_rc_low_source, 1'b1);
    repeat (8) @(posedge mclk);
    #1;
    chk(clk_sel_internal, 1'b0);
    rdchk(ADDR_OSCILLATOR_CONTROL, 8'h08);
    @(posedge mclk);
    clock_lost <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk(wdt_clear, 1'b1);
    chk(clk_sel_internal, 1'b1);
    chk(primary_osc_en, 1'b0);
    rdchk(ADDR_EVENT_STATUS, 8'h08);
    end_of_test();
  end
endmodule // pmw_power_mode_wake_control_test
